// ==== ure_rule_eval.sv ====
// Notes on behaviour
// - rule pointer ends past end marker
// - rule byte is unsigned offset from base
// - base pointer never modified
// - antecedents fold accumulator by minimum
// - consequents written only if accumulator larger than output
// - separator byte inverts list phase flag
// - consequent to antecedent separator reloads all ones
// - accumulator keeps last truth value at end
// - three cycle loop per rule byte
// - pending interrupt checked each loop pass
// - interrupt moves program counter back to instruction
// - interrupt steps rule pointer back by one
// - break only after loop cycle one, two fixups
// - read data used two cycles after read
// - one of first/last cycles fetches program
// - cycle two reads rule byte, cycle three idle
// - loop cycle one reads fuzzy value unless marker
// - loop cycle two fetches next byte unless end
// - phase flag picks minimum or write path
// - minimum cycle idle, still run on separator
`timescale 1ns/100ps
module ure_rule_eval
  import ure_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic        fetch_first_i,
  input  wire logic        irq_pending_i,
  input  wire logic [15:0] rule_ptr_i,
  input  wire logic [15:0] base_ptr_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic        phase_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             irq_taken_o,
  output logic [15:0]      rule_ptr_o,
  output logic [15:0]      base_ptr_o,
  output logic [15:0]      pc_o,
  output logic [7:0]       acc_o,
  output logic             phase_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic             mem_prog_o,
  output logic [15:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i
);

  ure_bus_if bus ();

  ure_bus_port u_port (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .bus         (bus.port),
    .mem_rd_o    (mem_rd_o),
    .mem_wr_o    (mem_wr_o),
    .mem_prog_o  (mem_prog_o),
    .mem_addr_o  (mem_addr_o),
    .mem_wdata_o (mem_wdata_o),
    .mem_rdata_i (mem_rdata_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_sep(input logic [7:0] b);
    is_sep = (b == URE_SEP);
  endfunction : is_sep

  function automatic logic is_end(input logic [7:0] b);
    is_end = (b == URE_END);
  endfunction : is_end

  function automatic logic is_marker(input logic [7:0] b);
    is_marker = is_sep(b) || is_end(b);
  endfunction : is_marker

  function automatic logic [15:0] fuzzy_addr(input logic [15:0] base,
                                             input logic [7:0]  off);
    fuzzy_addr = base + {8'h00, off};
  endfunction : fuzzy_addr

  function automatic logic [7:0] lower_of(input logic [7:0] a,
                                          input logic [7:0] b);
    lower_of = (b < a) ? b : a;
  endfunction : lower_of

  function automatic logic exceeds(input logic [7:0] a,
                                   input logic [7:0] b);
    exceeds = (a > b);
  endfunction : exceeds

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ure_state_t  state;
    logic        fetch_first;
    logic [15:0] xptr;
    logic [15:0] yptr;
    logic [15:0] pc;
    logic [7:0]  acc;
    logic        phase;
    logic [7:0]  rx;
    logic [7:0]  rnext;
    logic        done;
    logic        irq_taken;
  } ure_st_t;

  // one cycle of bus request, registered by the port stage
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        prog;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ure_req_t;

  ure_st_t  st;
  ure_st_t  next_st;
  ure_req_t req;

  ////////////////////////////////////////////////////////////////////////////
  // byte classes of the data returned now and of the held rule byte
  logic [7:0]  rd_byte;
  logic        new_sep;
  logic        new_marker;
  logic        held_end;
  logic        held_marker;

  // control decisions
  logic        accept;
  logic        irq_break;
  logic        reload_ones;
  logic        take_lower;
  logic        store_out;

  // datapath results
  logic [7:0]  min_value;
  logic [15:0] rd_fuzzy_addr;
  logic [15:0] wr_fuzzy_addr;
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] pc_dec;

  // the port stage returns read data two cycles after the request
  assign rd_byte       = bus.rdata;
  assign new_sep       = is_sep(rd_byte);
  assign new_marker    = is_marker(rd_byte);
  assign held_end      = is_end(st.rx);
  assign held_marker   = is_marker(st.rx);

  assign accept        = (st.state == URE_IDLE) && start_i;
  // break in C4 before any phase or accumulator change is kept
  assign irq_break     = (st.state == URE_C4) && irq_pending_i;
  assign reload_ones   = new_sep && st.phase;
  // marker passes read no fuzzy value, so the data returned is junk
  assign take_lower    = !st.phase && !held_marker;
  assign store_out     = st.phase && !held_marker &&
                         exceeds(st.acc, rd_byte);

  assign min_value     = lower_of(st.acc, rd_byte);
  assign rd_fuzzy_addr = fuzzy_addr(st.yptr, rd_byte);
  assign wr_fuzzy_addr = fuzzy_addr(st.yptr, st.rx);
  assign ptr_inc       = st.xptr + URE_ONE;
  assign ptr_dec       = st.xptr - URE_ONE;
  assign pc_dec        = st.pc - URE_PC_BACK;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st           = st;
    next_st.done      = 1'b0;
    next_st.irq_taken = 1'b0;
    req.rd            = 1'b0;
    req.wr            = 1'b0;
    req.prog          = 1'b0;
    req.addr          = 16'h0000;
    req.wdata         = 8'h00;
    unique case (st.state)
      URE_IDLE: begin
        if (accept) begin
          next_st.fetch_first = fetch_first_i;
          next_st.xptr        = rule_ptr_i;
          next_st.yptr        = base_ptr_i;
          next_st.pc          = pc_i;
          next_st.acc         = acc_i;
          next_st.phase       = phase_i;
          next_st.state       = URE_C1;
        end
      end
      URE_C1: begin
        req.prog      = st.fetch_first;
        req.addr      = st.pc;
        next_st.state = URE_C2;
      end
      URE_C2: begin
        // first rule byte, or the re-fetched one after an interrupt
        req.rd        = 1'b1;
        req.addr      = st.xptr;
        next_st.xptr  = ptr_inc;
        next_st.state = URE_C3;
      end
      URE_C3: begin
        next_st.state = URE_C4;
      end
      URE_C4: begin
        // rule byte requested in C2 or C5 arrives now
        next_st.rx = rd_byte;
        if (!new_marker) begin
          req.rd   = 1'b1;
          req.addr = rd_fuzzy_addr;
        end
        if (irq_break) begin
          // the pass restarts from the re-fetched byte on return
          next_st.state = URE_I5;
        end else begin
          if (new_sep) begin
            next_st.phase = ~st.phase;
          end
          if (reload_ones) begin
            next_st.acc = URE_ALL_ONES;
          end
          next_st.state = URE_C5;
        end
      end
      URE_C5: begin
        // the end marker pass fetches nothing further
        if (!held_end) begin
          req.rd       = 1'b1;
          req.addr     = st.xptr;
          next_st.xptr = ptr_inc;
        end
        next_st.state = URE_C6;
      end
      URE_C6: begin
        // fuzzy value read in C4 arrives now
        if (take_lower) begin
          next_st.acc = min_value;
        end
        if (store_out) begin
          req.wr    = 1'b1;
          req.addr  = wr_fuzzy_addr;
          req.wdata = st.acc;
        end
        if (held_end) begin
          next_st.state = URE_C7;
        end else begin
          next_st.state = URE_C4;
        end
      end
      URE_C7: begin
        // whichever optional cycle did not fetch stays free
        req.prog      = ~st.fetch_first;
        req.addr      = st.pc;
        next_st.done  = 1'b1;
        next_st.state = URE_IDLE;
      end
      URE_I5: begin
        next_st.pc    = pc_dec;
        next_st.state = URE_I6;
      end
      URE_I6: begin
        next_st.xptr      = ptr_dec;
        next_st.irq_taken = 1'b1;
        next_st.state     = URE_IDLE;
      end
      default: begin
        next_st.state = URE_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // requests leave through the registered port stage
  assign bus.rd    = req.rd;
  assign bus.wr    = req.wr;
  assign bus.prog  = req.prog;
  assign bus.addr  = req.addr;
  assign bus.wdata = req.wdata;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '{state: URE_IDLE, acc: URE_ALL_ONES, default: '0};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working registers are seen straight from the state flip-flops
  assign busy_o      = (st.state != URE_IDLE);
  assign done_o      = st.done;
  assign irq_taken_o = st.irq_taken;
  assign rule_ptr_o  = st.xptr;
  assign base_ptr_o  = st.yptr;
  assign pc_o        = st.pc;
  assign acc_o       = st.acc;
  assign phase_o     = st.phase;
endmodule : ure_rule_eval

// ==== ure_pkg.sv ====
package ure_pkg;
  localparam int          URE_DW       = 8;
  localparam int          URE_AW       = 16;
  localparam logic [7:0]  URE_ALL_ONES = 8'hFF;
  localparam logic [7:0]  URE_SEP      = 8'hFE;
  localparam logic [7:0]  URE_END      = 8'hFF;
  localparam logic [15:0] URE_PC_BACK  = 16'h0002;
  localparam logic [15:0] URE_ONE      = 16'h0001;

  typedef enum logic [3:0] {
    URE_IDLE,
    URE_C1,
    URE_C2,
    URE_C3,
    URE_C4,
    URE_C5,
    URE_C6,
    URE_C7,
    URE_I5,
    URE_I6
  } ure_state_t;
endpackage : ure_pkg

// ==== ure_bus_if.sv ====
`timescale 1ns/100ps
interface ure_bus_if;
  logic        rd;
  logic        wr;
  logic        prog;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport seq (output rd, output wr, output prog, output addr,
               output wdata, input rdata);
  modport port (input rd, input wr, input prog, input addr,
                input wdata, output rdata);
endinterface : ure_bus_if

// ==== ure_bus_port.sv ====
`timescale 1ns/100ps
module ure_bus_port
  import ure_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  ure_bus_if.port          bus,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic             mem_prog_o,
  output logic [15:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i
);
  // bus requests go out from flip-flops, read data is registered back
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        prog;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
  } ure_port_st_t;

  ure_port_st_t st;
  ure_port_st_t next_st;

  always_comb begin
    next_st       = st;
    next_st.rd    = bus.rd;
    next_st.wr    = bus.wr;
    next_st.prog  = bus.prog;
    next_st.addr  = bus.addr;
    next_st.wdata = bus.wdata;
    next_st.rdata = mem_rdata_i;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.rdata   = st.rdata;
  assign mem_rd_o    = st.rd;
  assign mem_wr_o    = st.wr;
  assign mem_prog_o  = st.prog;
  assign mem_addr_o  = st.addr;
  assign mem_wdata_o = st.wdata;
endmodule : ure_bus_port

// ==== ure_mem_model.sv ====
`timescale 1ns/100ps
module ure_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0]  mem [0:65535];
  logic        rd_q;
  logic [15:0] addr_q;
  always @(posedge mclk_i) begin
    rd_q   <= rd_i;
    addr_q <= addr_i;
    if (wr_i)
      mem[addr_i] <= wdata_i;
  end
  // data holds one cycle past the strobe, then turns to garbage
  assign rdata_o = rd_i ? mem[addr_i] : rd_q ? mem[addr_q] : ~mem[addr_q];
endmodule : ure_mem_model

// ==== ure_rule_eval_props.sv ====
`timescale 1ns/100ps
module ure_rule_eval_props
  import ure_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        start_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        irq_taken_o,
  input wire logic [15:0] base_ptr_o,
  input wire logic [7:0]  acc_o,
  input wire logic        phase_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [7:0]  mem_wdata_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_start; !busy_o && start_i; endsequence
  sequence s_ante2; busy_o && !phase_o ##1 busy_o && !phase_o; endsequence
  a_start_busy: assert property (s_start |=> busy_o)
    else $error("start did not raise busy");
  a_base_hold: assert property (busy_o ##1 busy_o |-> $stable(base_ptr_o))
    else $error("base pointer moved");
  a_min_fold: assert property (s_ante2 |-> acc_o <= $past(acc_o))
    else $error("accumulator rose in antecedents");
  a_wr_phase: assert property (mem_wr_o |-> phase_o)
    else $error("write outside consequents");
  a_wr_data: assert property (mem_wr_o |-> mem_wdata_o == acc_o)
    else $error("write data not accumulator");
  a_rw_excl: assert property (!(mem_rd_o && mem_wr_o))
    else $error("read and write together");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_irq_alone: assert property (irq_taken_o |-> !done_o ##1 !irq_taken_o)
    else $error("interrupt exit malformed");
endmodule : ure_rule_eval_props
bind ure_rule_eval ure_rule_eval_props ure_rule_eval_props_i (.mclk_i,
  .resetn_i, .start_i, .busy_o, .done_o, .irq_taken_o, .base_ptr_o, .acc_o,
  .phase_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o);

// ==== unweighted_rule_evaluator_tb.sv ====
`timescale 1ns/100ps
module unweighted_rule_evaluator_tb;
  import ure_pkg::*;
  logic mclk_i, resetn_i, start_i, fetch_first_i, irq_pending_i, phase_i;
  logic busy_o, done_o, irq_taken_o, phase_o, mem_rd_o, mem_wr_o, mem_prog_o;
  logic [15:0] rule_ptr_i, base_ptr_i, pc_i, rule_ptr_o, base_ptr_o, pc_o;
  logic [15:0] mem_addr_o;
  logic [7:0]  acc_i, acc_o, mem_wdata_o, mem_rdata_i;
  int          fails, checks_done, cyc, progs, irqs, tick;
  ure_rule_eval ure_rule_eval_i (.mclk_i, .resetn_i, .start_i, .fetch_first_i,
    .irq_pending_i, .rule_ptr_i, .base_ptr_i, .pc_i, .acc_i, .phase_i, .busy_o,
    .done_o, .irq_taken_o, .rule_ptr_o, .base_ptr_o, .pc_o, .acc_o, .phase_o,
    .mem_rd_o, .mem_wr_o, .mem_prog_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i);
  ure_mem_model ure_mem_model_i (.mclk_i, .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    tick++;
    if (mem_prog_o === 1'b1)
      progs++;
    if (irq_taken_o === 1'b1)
      irqs++;
    if (tick == 3000) begin
      fails++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results;
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic go(input logic ff, irq, input logic [15:0] p,
                    input logic [7:0] a, input logic ph);
    @(posedge mclk_i);
    {fetch_first_i, irq_pending_i, rule_ptr_i} <= {ff, irq, p};
    {acc_i, phase_i, start_i} <= {a, ph, 1'b1};
    progs = 0;
    irqs = 0;
    cyc = 0;
    @(posedge mclk_i);
    start_i <= 1'b0;
    // a hang is caught by the cycle ceiling
    while (!(done_o === 1'b1 || irq_taken_o === 1'b1)) begin
      @(negedge mclk_i);
      cyc++;
    end
    // one more edge so a closing program fetch is counted
    @(posedge mclk_i);
    irq_pending_i <= 1'b0;
    @(negedge mclk_i);
  endtask : go
  task automatic load;
    {ure_mem_model_i.mem[16'h0210], ure_mem_model_i.mem[16'h0212]} = 16'h0;
    ure_mem_model_i.mem[16'h0291] = 8'h50;
  endtask : load
  task automatic t_rules(input logic ff);
    load();
    go(ff, 1'b0, 16'h0100, 8'hFF, 1'b0);
    chk("cycles", 16'(cyc), 16'h0023);
    chk("no irq", 16'(irqs), 16'h0000);
    chk("prog", 16'(progs), 16'h0001);
    chk("out0", {8'h0, ure_mem_model_i.mem[16'h0210]}, 16'h0040);
    chk("out1", {8'h0, ure_mem_model_i.mem[16'h0291]}, 16'h0050);
    chk("out2", {8'h0, ure_mem_model_i.mem[16'h0212]}, 16'h0090);
    chk("acc", {8'h0, acc_o}, 16'h0090);
    chk("phase", {15'h0, phase_o}, 16'h0001);
    chk("ptr", rule_ptr_o, 16'h010A);
    chk("base", base_ptr_o, 16'h0200);
  endtask : t_rules
  task automatic t_bad;
    go(1'b1, 1'b0, 16'h0120, 8'hFF, 1'b0);
    chk("bad acc", {8'h0, acc_o}, 16'h0080);
    chk("bad phase", {15'h0, phase_o}, 16'h0000);
    chk("bad ptr", rule_ptr_o, 16'h0122);
  endtask : t_bad
  task automatic t_irq;
    load();
    go(1'b1, 1'b1, 16'h0100, 8'hFF, 1'b0);
    chk("irq", 16'(irqs), 16'h0001);
    chk("irq pc", pc_o, 16'h4000 - URE_PC_BACK);
    chk("irq ptr", rule_ptr_o, 16'h0100);
    go(1'b1, 1'b0, rule_ptr_o, acc_o, phase_o);
    chk("resume", {ure_mem_model_i.mem[16'h0212], acc_o}, 16'h9090);
  endtask : t_irq
  initial begin
    {mclk_i, resetn_i, start_i, fetch_first_i, irq_pending_i, phase_i} = '0;
    {rule_ptr_i, base_ptr_i, pc_i, acc_i} = {16'h0, 16'h0200, 16'h4000, 8'hFF};
    for (int i = 0; i < 10; i++)
      ure_mem_model_i.mem[16'h0100 + i] = 80'h0081FE1091FE02FE12FF >> (72 - 8 * i);
    {ure_mem_model_i.mem[16'h0120], ure_mem_model_i.mem[16'h0121]} = 16'h81FF;
    {ure_mem_model_i.mem[16'h0200], ure_mem_model_i.mem[16'h0281]} = 16'h4080;
    ure_mem_model_i.mem[16'h0202] = 8'h90;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    t_rules(1'b1);
    t_rules(1'b0);
    t_bad();
    t_irq();
    results();
  end
endmodule : unweighted_rule_evaluator_tb
